/* include/crtr_pkg.sv */
// constants for the codec record transfer register group
package crtr_pkg;
   // ----------------------------------------------------------------
   // register byte offsets on the processor address bus
   // ----------------------------------------------------------------
   localparam logic [5:0] OFS_ROW_LEN_LO = 6'h1C;
   localparam logic [5:0] OFS_ROW_LEN_HI = 6'h1D;
   localparam logic [5:0] OFS_CREC_LO = 6'h20;
   localparam logic [5:0] OFS_CREC_HI = 6'h21;
   localparam logic [5:0] OFS_STATUS = 6'h27;
   localparam logic [5:0] OFS_MASK = 6'h29;
   localparam logic [5:0] OFS_DREC_LO = 6'h2C;
   localparam logic [5:0] OFS_DREC_HI = 6'h2D;
   localparam logic [5:0] OFS_TALLY_B0 = 6'h30;
   localparam logic [5:0] OFS_TALLY_B1 = 6'h31;
   localparam logic [5:0] OFS_TALLY_B2 = 6'h32;
   localparam logic [5:0] OFS_TALLY_B3 = 6'h33;
   localparam logic [5:0] OFS_CPRE = 6'h34;
   localparam logic [5:0] OFS_PATTERN = 6'h35;
   localparam logic [5:0] OFS_DPRE = 6'h38;
   localparam logic [5:0] OFS_TEST = 6'h3A;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int BIT_COMP_END = 0;
   localparam int BIT_DECOMP_END = 1;
   localparam int BIT_PRE_EN = 7;
   localparam int BIT_FILL = 6;
   localparam int ROW_LEN_W = 11;
   localparam int CFG_DIR_POL = 0;
   localparam int CFG_CS_MODE = 1;
   // ----------------------------------------------------------------
   // reset values and writable-bit masks
   // ----------------------------------------------------------------
   localparam logic [15:0] REC_RESET = 16'hFFFF;
   localparam logic [7:0] MASK_RESET = 8'hFF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [1:0] STATUS_RESET = 2'h0;
   localparam logic [ROW_LEN_W-1:0] ROW_LEN_RESET = 11'h000;
   localparam logic [31:0] TALLY_RESET = 32'h0000_0000;
   localparam logic [7:0] CPRE_WMASK = 8'hBB;
   localparam logic [7:0] DPRE_WMASK = 8'hFB;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // ----------------------------------------------------------------
   // word sizes in bytes for the tally, by bus width setting
   // ----------------------------------------------------------------
   localparam logic [31:0] WORD_BYTES_WIDE = 32'h0000_0004;
   localparam logic [31:0] WORD_BYTES_NARROW = 32'h0000_0002;
   // ----------------------------------------------------------------
   // host access sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ACC_IDLE = 3'b001,
      ACC_EXEC = 3'b010,
      ACC_DONE = 3'b100
   } crtr_acc_e;
endpackage

/* rtl/crtr_regs.sv */
// codec record transfer register group behind the 8-bit host port
// Notes on behaviour
// - eleven-bit row length at 0x1C/0x1D, minimum 16
// - compression record counter decrements per record end
// - compression end flag sets at zero, W1C
// - decompression end flag sets at zero, W1C
// - mask bits block their flag from interrupt
// - decompression counter expiry posts end interrupt
// - tally counts output bytes rounded to word
// - tally cleared at record start, queue clear
// - compression preload register mirrors control bits
// - decompression preload register adds fill bit
// - fill pattern byte feeds blank records
// - six-bit address selects the register
// - one-cycle chip select starts whole access
// - config pin zero sets direction polarity
// - ready low marks read data or write done
// - preload copied into control at record end
// - fill mode cleared when decompression count zero
`timescale 1ns/1ps
module crtr_regs
   import crtr_pkg::*;
#(
   parameter int TALLY_W = 32  // width of the compressed byte tally
) (
   input wire logic mclk_i,                        // device clock, 125 MHz
   input wire logic rst_b_i,                       // async reset, active low
   input wire logic [5:0] proc_address_bus_i,      // register address
   input wire logic [7:0] proc_data_bus_i,         // host data toward device
   output logic [7:0] proc_data_bus_o,             // read data toward host
   output logic proc_data_bus_oe_o,                // high while device drives data
   input wire logic chip_select_n_i,               // access start, active low
   input wire logic dir_i,                         // read/write direction
   input wire logic [1:0] host_port_config_i,      // direction polarity, ready mode
   output logic access_done_n_o,                   // ready, active low
   output logic interrupt_out_n_o,                 // interrupt, active low
   input wire logic comp_record_end_i,             // last record byte compressed
   input wire logic decomp_record_end_i,           // last record byte decompressed
   input wire logic comp_eor_out_i,                // end of record leaves compressor
   input wire logic decomp_eor_out_i,              // end of record leaves decompressor
   input wire logic comp_record_start_i,           // new compressed record begins
   input wire logic comp_out_word_i,               // one word left output queue
   input wire logic comp_out_queue_clear_i,        // output queue reset level
   input wire logic wide_i,                        // bus width: 1 wide, 0 narrow
   output logic comp_ctrl_load_o,                  // preload copy pulse, compression
   output logic [7:0] comp_ctrl_value_o,           // value copied to compression control
   output logic decomp_ctrl_load_o,                // preload copy pulse, decompression
   output logic [7:0] decomp_ctrl_value_o,         // value copied to decompression control
   output logic decomp_fill_mode_o,                // blank-record fill active
   output logic [7:0] fill_pattern_o,              // byte repeated during fill
   output logic [ROW_LEN_W-1:0] decomp_row_length_o // bytes per scan row
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   crtr_acc_e acc_state;                  // host access sequencer
   logic [5:0] acc_addr;                  // captured address
   logic [7:0] acc_wdata;                 // captured write data
   logic acc_read;                        // captured direction, 1 = read
   logic [ROW_LEN_W-1:0] decomp_row_length; // row length field
   logic [15:0] comp_record_counter;      // records left, compression
   logic [15:0] decomp_record_counter;    // records left, decompression
   logic [1:0] transfer_end_status;       // sticky end-of-transfer flags
   logic [7:0] transfer_end_mask;         // interrupt masks
   logic [TALLY_W-1:0] compressed_byte_tally; // bytes out this record
   logic [7:0] comp_ctrl_preload;         // compression preload
   logic [7:0] decomp_ctrl_preload;       // decompression preload
   logic [7:0] fill_pattern;              // blank record byte
   logic [7:0] decomp_test_reserved;      // production test byte
   logic [7:0] next_rdata;                // read mux result
   logic wr_en;                           // write strobe in exec cycle
   logic comp_hits_zero;                  // compression count reaches zero
   logic decomp_hits_zero;                // decompression count reaches zero
   logic [TALLY_W-1:0] word_bytes;        // tally step for this bus width

   // execute cycle performs the register write
   assign wr_en = (acc_state == ACC_EXEC) && !acc_read;

   // decrement of one ends the transfer
   assign comp_hits_zero = comp_record_end_i && (comp_record_counter == 16'h0001);
   assign decomp_hits_zero = decomp_record_end_i && (decomp_record_counter == 16'h0001);

   // step is the full word, so partial words round up naturally
   assign word_bytes = wide_i ? TALLY_W'(WORD_BYTES_WIDE) : TALLY_W'(WORD_BYTES_NARROW);

   // ----------------------------------------------------------------
   // host access sequencer
   // ----------------------------------------------------------------
   // chip select only starts an access in idle, so a held select does not
   // restart an access while the previous one is still completing
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         acc_state <= ACC_IDLE;
      end else begin
         unique case (acc_state)
            ACC_IDLE: begin
               if (!chip_select_n_i) begin
                  acc_state <= ACC_EXEC;
               end
            end
            ACC_EXEC: begin
               acc_state <= ACC_DONE;
            end
            ACC_DONE: begin
               if (host_port_config_i[CFG_CS_MODE] || chip_select_n_i) begin
                  acc_state <= ACC_IDLE;
               end
            end
         endcase
      end
   end

   // capture of address, direction and data at the start edge
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         acc_addr <= 6'h00;
         acc_wdata <= BYTE_ZERO;
         acc_read <= 1'b0;
      end else if (acc_state == ACC_IDLE && !chip_select_n_i) begin
         acc_addr <= proc_address_bus_i;
         acc_wdata <= proc_data_bus_i;
         acc_read <= dir_i ^ host_port_config_i[CFG_DIR_POL];
      end
   end

   // ----------------------------------------------------------------
   // read path and ready
   // ----------------------------------------------------------------
   // read mux, reserved bits and unmapped addresses read as zero
   always_comb begin
      next_rdata = READ_UNMAPPED;
      unique case (acc_addr)
         OFS_ROW_LEN_LO: next_rdata = decomp_row_length[7:0];
         OFS_ROW_LEN_HI: next_rdata = {5'h00, decomp_row_length[10:8]};
         OFS_CREC_LO: next_rdata = comp_record_counter[7:0];
         OFS_CREC_HI: next_rdata = comp_record_counter[15:8];
         OFS_STATUS: next_rdata = {6'h00, transfer_end_status};
         OFS_MASK: next_rdata = transfer_end_mask;
         OFS_DREC_LO: next_rdata = decomp_record_counter[7:0];
         OFS_DREC_HI: next_rdata = decomp_record_counter[15:8];
         OFS_TALLY_B0: next_rdata = compressed_byte_tally[7:0];
         OFS_TALLY_B1: next_rdata = compressed_byte_tally[15:8];
         OFS_TALLY_B2: next_rdata = compressed_byte_tally[23:16];
         OFS_TALLY_B3: next_rdata = compressed_byte_tally[31:24];
         OFS_CPRE: next_rdata = comp_ctrl_preload;
         OFS_PATTERN: next_rdata = fill_pattern;
         OFS_DPRE: next_rdata = decomp_ctrl_preload;
         OFS_TEST: next_rdata = decomp_test_reserved;
         default: next_rdata = READ_UNMAPPED;
      endcase
   end

   // read data is latched in exec and held through the done phase
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         proc_data_bus_o <= BYTE_ZERO;
         proc_data_bus_oe_o <= 1'b0;
         access_done_n_o <= 1'b1;
      end else begin
         if (acc_state == ACC_EXEC) begin
            proc_data_bus_o <= next_rdata;
         end
         if (acc_state == ACC_EXEC) begin
            access_done_n_o <= 1'b0;
            proc_data_bus_oe_o <= acc_read;
         end else if (acc_state == ACC_DONE &&
                      (host_port_config_i[CFG_CS_MODE] || chip_select_n_i)) begin
            access_done_n_o <= 1'b1;
            proc_data_bus_oe_o <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // plain configuration registers
   // ----------------------------------------------------------------
   // row length, pattern, masks, preloads and test byte; reserved
   // bits are dropped on write since software must write them zero
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         decomp_row_length <= ROW_LEN_RESET;
         fill_pattern <= BYTE_ZERO;
         transfer_end_mask <= MASK_RESET;
         comp_ctrl_preload <= BYTE_ZERO;
         decomp_ctrl_preload <= BYTE_ZERO;
         decomp_test_reserved <= BYTE_ZERO;
      end else if (wr_en) begin
         unique case (acc_addr)
            OFS_ROW_LEN_LO: decomp_row_length[7:0] <= acc_wdata;
            OFS_ROW_LEN_HI: decomp_row_length[10:8] <= acc_wdata[2:0];
            OFS_MASK: transfer_end_mask <= acc_wdata;
            OFS_CPRE: comp_ctrl_preload <= acc_wdata & CPRE_WMASK;
            OFS_PATTERN: fill_pattern <= acc_wdata;
            OFS_DPRE: decomp_ctrl_preload <= acc_wdata & DPRE_WMASK;
            OFS_TEST: decomp_test_reserved <= acc_wdata;
            default: begin
               // other addresses handled elsewhere or ignored
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // record counters
   // ----------------------------------------------------------------
   // a host byte write in the same cycle as a record end wins, so
   // the written byte is kept and the decrement of that cycle is dropped
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         comp_record_counter <= REC_RESET;
      end else if (wr_en && acc_addr == OFS_CREC_LO) begin
         comp_record_counter[7:0] <= acc_wdata;
      end else if (wr_en && acc_addr == OFS_CREC_HI) begin
         comp_record_counter[15:8] <= acc_wdata;
      end else if (comp_record_end_i) begin
         comp_record_counter <= comp_record_counter - 16'h0001;
      end
   end

   // decompression counter, same priority as compression
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         decomp_record_counter <= REC_RESET;
      end else if (wr_en && acc_addr == OFS_DREC_LO) begin
         decomp_record_counter[7:0] <= acc_wdata;
      end else if (wr_en && acc_addr == OFS_DREC_HI) begin
         decomp_record_counter[15:8] <= acc_wdata;
      end else if (decomp_record_end_i) begin
         decomp_record_counter <= decomp_record_counter - 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // end-of-transfer flags and interrupt
   // ----------------------------------------------------------------
   // one flop per flag; a set in the clearing cycle survives
   generate
      for (genvar i = 0; i < 2; i++) begin : g_flag
         logic set_ev;   // hardware event for this flag
         logic clr_ev;   // software write of one
         assign set_ev = (i == BIT_COMP_END) ? comp_hits_zero : decomp_hits_zero;
         assign clr_ev = wr_en && (acc_addr == OFS_STATUS) && acc_wdata[i];
         always_ff @(posedge mclk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               transfer_end_status[i] <= STATUS_RESET[i];
            end else if (set_ev) begin
               transfer_end_status[i] <= 1'b1;
            end else if (clr_ev) begin
               transfer_end_status[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // interrupt follows status one cycle later, registered for a clean pin
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         interrupt_out_n_o <= 1'b1;
      end else begin
         interrupt_out_n_o <= ~|(transfer_end_status & ~transfer_end_mask[1:0]);
      end
   end

   // ----------------------------------------------------------------
   // compressed byte tally
   // ----------------------------------------------------------------
   // clear has top priority: a queue reset must never leave stale counts
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         compressed_byte_tally <= TALLY_W'(TALLY_RESET);
      end else if (comp_record_start_i || comp_out_queue_clear_i) begin
         compressed_byte_tally <= TALLY_W'(TALLY_RESET);
      end else if (wr_en && acc_addr == OFS_TALLY_B0) begin
         compressed_byte_tally[7:0] <= acc_wdata;
      end else if (wr_en && acc_addr == OFS_TALLY_B1) begin
         compressed_byte_tally[15:8] <= acc_wdata;
      end else if (wr_en && acc_addr == OFS_TALLY_B2) begin
         compressed_byte_tally[23:16] <= acc_wdata;
      end else if (wr_en && acc_addr == OFS_TALLY_B3) begin
         compressed_byte_tally[31:24] <= acc_wdata;
      end else if (comp_out_word_i) begin
         compressed_byte_tally <= compressed_byte_tally + word_bytes;
      end
   end

   // ----------------------------------------------------------------
   // preload copy toward the control registers
   // ----------------------------------------------------------------
   // control registers live with the engines; this block offers the
   // value and a one-cycle load pulse at each record end whose preload has BIT_PRE_EN set
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         comp_ctrl_load_o <= 1'b0;
         comp_ctrl_value_o <= BYTE_ZERO;
         decomp_ctrl_load_o <= 1'b0;
         decomp_ctrl_value_o <= BYTE_ZERO;
      end else begin
         comp_ctrl_load_o <= comp_eor_out_i && comp_ctrl_preload[BIT_PRE_EN];
         decomp_ctrl_load_o <= decomp_eor_out_i && decomp_ctrl_preload[BIT_PRE_EN];
         if (comp_eor_out_i && comp_ctrl_preload[BIT_PRE_EN]) begin
            comp_ctrl_value_o <= comp_ctrl_preload;
         end
         if (decomp_eor_out_i && decomp_ctrl_preload[BIT_PRE_EN]) begin
            decomp_ctrl_value_o <= decomp_ctrl_preload;
         end
      end
   end

   // fill mode enters with a preload carrying the fill bit and ends at
   // transfer end; the end wins so a stale fill never outlives it
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         decomp_fill_mode_o <= 1'b0;
      end else if (decomp_hits_zero) begin
         decomp_fill_mode_o <= 1'b0;
      end else if (decomp_eor_out_i && decomp_ctrl_preload[BIT_PRE_EN]) begin
         decomp_fill_mode_o <= decomp_ctrl_preload[BIT_FILL];
      end
   end

   // registered copies of configuration for the engines
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fill_pattern_o <= BYTE_ZERO;
         decomp_row_length_o <= ROW_LEN_RESET;
      end else begin
         fill_pattern_o <= fill_pattern;
         decomp_row_length_o <= decomp_row_length;
      end
   end

endmodule

/* tb/crtr_host.sv */
// host processor model driving the register port
`timescale 1ns/1ps
module crtr_host (
   input wire logic mclk_i, // device clock
   input wire logic access_done_n_i, // ready, active low
   input wire logic [7:0] rdata_i, // read data
   input wire logic rdata_oe_i, // device drives data
   input wire logic [1:0] cfg_i, // port mode pins
   output logic chip_select_n_o, // select, active low
   output logic [5:0] addr_o, // register address
   output logic [7:0] wdata_o, // write data
   output logic dir_o // direction
);
   logic hold = 1'b0; // keep select low until ready
   initial begin
      chip_select_n_o = 1'b1;
      addr_o = 6'h2A;
      wdata_o = 8'h5A;
      dir_o = 1'b0;
   end
   // port is private, no data traffic shares it
   // select low one cycle unless hold
   task acc(input logic rd, input logic [5:0] a, input logic [7:0] wd, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge mclk_i);
      chip_select_n_o <= 1'b0;
      addr_o <= a;
      wdata_o <= wd;
      dir_o <= rd ^ cfg_i[0];
      do begin
         @(posedge mclk_i);
         if (!hold && n == 0) chip_select_n_o <= 1'b1;
         n++;
      end while (access_done_n_i !== 1'b0 && n < 8);
      q = (rdata_oe_i === 1'b1) ? rdata_i : 8'hXX;
      // stale address and data must not look valid
      chip_select_n_o <= 1'b1;
      addr_o <= ~a;
      wdata_o <= ~wd;
   endtask
endmodule

/* tb/crtr_regs_sva.sv */
// assertions on the host port and preload outputs of the register group
`timescale 1ns/1ps
module crtr_regs_sva (
   input wire logic mclk_i, // clock
   input wire logic rst_b_i, // reset, active low
   input wire logic chip_select_n_i, // select, active low
   input wire logic dir_i, // direction
   input wire logic [1:0] host_port_config_i, // port mode
   input wire logic access_done_n_o, // ready, active low
   input wire logic proc_data_bus_oe_o, // read drive
   input wire logic comp_eor_out_i, // comp record out
   input wire logic decomp_eor_out_i, // decomp record out
   input wire logic comp_ctrl_load_o, // comp copy pulse
   input wire logic [7:0] comp_ctrl_value_o, // comp copy value
   input wire logic decomp_ctrl_load_o, // decomp copy pulse
   input wire logic [7:0] decomp_ctrl_value_o, // decomp copy value
   input wire logic decomp_fill_mode_o // fill active
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   // ready gone again one edge later
   sequence s_rel; ##1 access_done_n_o; endsequence
   // select is taken two edges before ready is first seen low
   property p_ready_lat; $fell(access_done_n_o) |-> !$past(chip_select_n_i, 2); endproperty
   a_ready_lat: assert property (p_ready_lat) else $error("ready without take");
   property p_one_cyc; !access_done_n_o && host_port_config_i[1] |-> s_rel; endproperty
   a_one_cyc: assert property (p_one_cyc) else $error("ready too long");
   property p_held; !access_done_n_o && !host_port_config_i[1] && !chip_select_n_i |=>
      !access_done_n_o; endproperty
   a_held: assert property (p_held) else $error("ready dropped early");
   property p_oe_rdy; proc_data_bus_oe_o |-> !access_done_n_o; endproperty
   a_oe_rdy: assert property (p_oe_rdy) else $error("drive outside ready");
   property p_oe_dir; $fell(access_done_n_o) |->
      proc_data_bus_oe_o == ($past(dir_i, 2) ^ $past(host_port_config_i[0], 2)); endproperty
   a_oe_dir: assert property (p_oe_dir) else $error("direction misread");
   property p_cload; comp_ctrl_load_o |-> $past(comp_eor_out_i) && comp_ctrl_value_o[7];
   endproperty
   a_cload: assert property (p_cload) else $error("bad comp copy");
   property p_dload; decomp_ctrl_load_o |-> $past(decomp_eor_out_i) && decomp_ctrl_value_o[7];
   endproperty
   a_dload: assert property (p_dload) else $error("bad decomp copy");
   property p_fill; $rose(decomp_fill_mode_o) |-> decomp_ctrl_load_o && decomp_ctrl_value_o[6];
   endproperty
   a_fill: assert property (p_fill) else $error("fill without copy");
endmodule
bind crtr_regs crtr_regs_sva u_sva (.mclk_i, .rst_b_i, .chip_select_n_i, .dir_i,
   .host_port_config_i, .access_done_n_o, .proc_data_bus_oe_o, .comp_eor_out_i,
   .decomp_eor_out_i, .comp_ctrl_load_o, .comp_ctrl_value_o, .decomp_ctrl_load_o,
   .decomp_ctrl_value_o, .decomp_fill_mode_o);

/* tb/testbench.sv */
// self-checking bench for the codec record transfer register group
`timescale 1ns/1ps
`define CHK(n, e, v) cmp(n, 32'(e), 32'(v))
module testbench;
   logic mclk_i = 1'b0; // clock
   logic rst_b_i = 1'b0; // reset, active low
   logic [1:0] cfg = 2'h3; // port mode
   logic wide = 1'b1; // bus width
   logic [6:0] ev = 7'h00; // event pulses
   logic chip_select_n, dir, oe, rdy_n, int_n, cld, dld, fill;
   logic [5:0] pa;
   logic [7:0] wd, rdat, cval, dval, pat, q;
   logic [10:0] rlen;
   int mismatches = 0;
   int total_checks = 0;
   always #4 mclk_i = ~mclk_i;
   crtr_regs dut (.mclk_i, .rst_b_i, .proc_address_bus_i(pa), .proc_data_bus_i(wd),
      .proc_data_bus_o(rdat), .proc_data_bus_oe_o(oe), .chip_select_n_i(chip_select_n), .dir_i(dir),
      .host_port_config_i(cfg), .access_done_n_o(rdy_n), .interrupt_out_n_o(int_n),
      .comp_record_end_i(ev[0]), .decomp_record_end_i(ev[1]), .comp_eor_out_i(ev[2]),
      .decomp_eor_out_i(ev[3]), .comp_record_start_i(ev[4]), .comp_out_word_i(ev[5]),
      .comp_out_queue_clear_i(ev[6]), .wide_i(wide), .comp_ctrl_load_o(cld),
      .comp_ctrl_value_o(cval), .decomp_ctrl_load_o(dld), .decomp_ctrl_value_o(dval),
      .decomp_fill_mode_o(fill), .fill_pattern_o(pat), .decomp_row_length_o(rlen));
   crtr_host host (.mclk_i, .access_done_n_i(rdy_n), .rdata_i(rdat), .rdata_oe_i(oe),
      .cfg_i(cfg), .chip_select_n_o(chip_select_n), .addr_o(pa), .wdata_o(wd), .dir_o(dir));
   task cmp(input string n, input logic [31:0] e, input logic [31:0] v);
      total_checks++;
      if (v !== e) begin
         mismatches++;
         $display("unexpected %s exp %h got %h", n, e, v);
      end
   endtask
   task wr(input logic [5:0] a, input logic [7:0] d);
      host.acc(1'b0, a, d, q);
   endtask
   task rc(input logic [5:0] a, input logic [7:0] e);
      host.acc(1'b1, a, 8'h00, q);
      `CHK($sformatf("reg %h", a), e, q);
   endtask
   // one-cycle event pulse, then let it settle
   task pulse(input int i);
      @(posedge mclk_i);
      ev[i] <= 1'b1;
      @(posedge mclk_i);
      ev <= 7'h00;
      repeat (2) @(posedge mclk_i);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      rc(6'h20, 8'hFF);
      rc(6'h2D, 8'hFF);
      rc(6'h27, 8'h00);
      rc(6'h29, 8'hFF);
      rc(6'h34, 8'h00);
      rc(6'h38, 8'h00);
      rc(6'h3A, 8'h00);
      rc(6'h3F, 8'h00);
      // row length written at the minimum of 16; reserved bits always written zero
      wr(6'h1C, 8'h10);
      wr(6'h1D, 8'h00);
      // registered copies lag the write by one edge, so look off the edge
      @(negedge mclk_i);
      `CHK("row minimum", 11'h010, rlen);
      wr(6'h1D, 8'h07);
      rc(6'h1D, 8'h07);
      `CHK("row length", 11'h710, rlen);
      wr(6'h34, 8'hBB);
      rc(6'h34, 8'hBB);
      wr(6'h35, 8'hA5);
      @(negedge mclk_i);
      `CHK("pattern", 8'hA5, pat);
      // every port mode, held select where ready waits for it
      for (int c = 0; c < 4; c++) begin
         @(posedge mclk_i);
         cfg <= 2'(c);
         host.hold <= ~c[1];
         rc(6'h35, 8'hA5);
      end
      wr(6'h34, 8'h81);
      pulse(2);
      `CHK("comp copy", 8'h81, cval);
      wr(6'h38, 8'hC0);
      pulse(3);
      `CHK("decomp copy", 8'hC0, dval);
      `CHK("fill on", 1'b1, fill);
      wr(6'h29, 8'h02);
      wr(6'h20, 8'h01);
      wr(6'h21, 8'h00);
      pulse(0);
      rc(6'h20, 8'h00);
      rc(6'h27, 8'h01);
      `CHK("irq comp", 1'b0, int_n);
      wr(6'h27, 8'h00);
      rc(6'h27, 8'h01);
      wr(6'h27, 8'h01);
      rc(6'h27, 8'h00);
      `CHK("irq clear", 1'b1, int_n);
      wr(6'h2C, 8'h01);
      wr(6'h2D, 8'h00);
      pulse(1);
      `CHK("fill off", 1'b0, fill);
      rc(6'h27, 8'h02);
      `CHK("irq masked", 1'b1, int_n);
      wr(6'h29, 8'h00);
      repeat (2) @(posedge mclk_i);
      `CHK("irq decomp", 1'b0, int_n);
      repeat (3) pulse(5);
      rc(6'h30, 8'h0C);
      @(posedge mclk_i) wide <= 1'b0;
      pulse(5);
      rc(6'h30, 8'h0E);
      pulse(4);
      rc(6'h30, 8'h00);
      pulse(5);
      pulse(6);
      rc(6'h30, 8'h00);
      end_sim();
   end
   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      repeat (3000) @(posedge mclk_i);
      mismatches++;
      end_sim();
   end
endmodule
